// ---- rtl/tccad_attach_detect.sv ----
// Purpose: Type-C CC attach, orientation and detach decisions
// Assumes: CC comparator bits are synchronous to SYS_CLK
// Notes: Disconnect threshold is picked by the analog side from RP_LEVEL
// Contract
// - Source, both open: nothing attached, no power
// - Source, Rd CC1: sink, VBUS, watch CC1
// - Source, Rd CC2: sink, VBUS, watch CC2
// - Source, Ra CC1: cable only, no power
// - Source, Ra CC2: cable only, no power
// - Ra CC1, Rd CC2: VBUS, VCONN CC1, watch CC2
// - Rd CC1, Ra CC2: VBUS, VCONN CC2, watch CC1
// - Rd both: debug accessory, either pin detaches
// - Ra both: audio accessory, either pin detaches
// - Default pullup until VBUS switch closes
// - Ra on a pin means active cable
// - Detach after threshold held for qualification time
// - Sink pulls down, attaches on VBUS, decodes current
// - Dual role alternates pulldown and pullup
// - Dead battery Rd until power not needed
// - CC overvoltage or reverse current kills VCONN, transmitter
// - Overtemperature latch enters error recovery
`timescale 1ns/1ps
`include "tccad_map.svh"
module tccad_attach_detect #(
    parameter int unsigned CC_QUAL_CYC = `TCCAD_CC_QUAL_CYC,
    parameter int unsigned DRP_PERIOD_CYC = `TCCAD_DRP_PERIOD_CYC,
    parameter int unsigned DRP_DUTY_PCT = `TCCAD_DRP_DUTY_PCT
) (
    input wire logic SYS_CLK, // 200 MHz clock
    input wire logic RST_N, // Synchronous reset, low
    input wire tccad_pkg::tccad_role_type ROLE_MODE, // Source, sink or dual role
    input wire tccad_pkg::tccad_cc_type CC1_SENSE, // CC1 comparators
    input wire tccad_pkg::tccad_cc_type CC2_SENSE, // CC2 comparators
    input wire logic VBUS_PRESENT, // VBUS above attach level
    input wire logic REV_CURRENT, // Reverse current into 5 V supply
    input wire logic OT_LATCH, // VCONN switch latched off by heat
    input wire logic DEAD_BATT, // Dead or no battery
    input wire logic VBUS_NOT_NEEDED, // Local power is up
    input wire logic [1:0] RP_LEVEL_REQ, // Firmware pullup level
    output logic CC_PULLUP, // 1 pullup current, 0 sink pulldown
    output logic [1:0] RP_LEVEL, // Active pullup level
    output logic VBUS_EN, // Source 5 V switch to VBUS
    output logic VCONN_CC1, // VCONN supply switch onto CC1
    output logic VCONN_CC2, // VCONN supply switch onto CC2
    output logic PD_TX_EN, // Power delivery transmitter enable
    output logic WATCH_CC1, // CC1 watched for detach
    output logic WATCH_CC2, // CC2 watched for detach
    output logic ATTACHED, // Attach status
    output logic ORIENT, // 0 partner on CC1, 1 on CC2
    output tccad_pkg::tccad_conn_type CONN_STATE, // Decoded connection
    output logic [1:0] SINK_CURRENT, // Advertised current as sink
    output logic DB_RD_EN, // Dead battery Rd
    output logic ERR_RECOVERY // Error recovery state
);
    import tccad_pkg::*;

    localparam int unsigned DRP_SRC_CYC = int'((longint'(DRP_PERIOD_CYC) * DRP_DUTY_PCT) / 100);

    tccad_ctl_type s;
    tccad_ctl_type next_s;
    tccad_conn_type cur;
    logic fault;
    logic src_phase;
    logic qual_cond;
    logic qual_done;

    // Priority: pairs first, so a pair is never read as a single pin
    function automatic tccad_conn_type src_decode(input tccad_cc_type a, input tccad_cc_type b);
        if (a.rd && b.rd) begin
            return CONN_DEBUG;
        end else if (a.ra && b.ra) begin
            return CONN_AUDIO;
        end else if (a.ra && b.rd) begin
            return CONN_VC_CC1;
        end else if (a.rd && b.ra) begin
            return CONN_VC_CC2;
        end else if (a.rd) begin
            return CONN_SINK_CC1;
        end else if (b.rd) begin
            return CONN_SINK_CC2;
        end else if (a.ra) begin
            return CONN_CABLE_CC1;
        end else if (b.ra) begin
            return CONN_CABLE_CC2;
        end else begin
            return CONN_NONE;
        end
    endfunction

    function automatic logic cable_only(input tccad_conn_type c);
        return (c == CONN_CABLE_CC1) || (c == CONN_CABLE_CC2);
    endfunction

    function automatic logic [1:0] watch_of(input tccad_conn_type c);
        case (c)
            CONN_SINK_CC1: return 2'h1;
            CONN_SINK_CC2: return 2'h2;
            CONN_CABLE_CC1: return 2'h1;
            CONN_CABLE_CC2: return 2'h2;
            CONN_VC_CC1: return 2'h2;
            CONN_VC_CC2: return 2'h1;
            CONN_DEBUG: return 2'h3;
            CONN_AUDIO: return 2'h3;
            CONN_NONE: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    assign fault = CC1_SENSE.ovp || CC2_SENSE.ovp || REV_CURRENT;
    assign src_phase = (ROLE_MODE == ROLE_SRC) || (ROLE_MODE == ROLE_DRP && s.drp_src);
    assign cur = src_decode(CC1_SENSE, CC2_SENSE);

    // Either watched pin above threshold counts
    assign qual_cond = (s.st == ST_ATT) && (s.conn != CONN_AS_SINK)
        && ((s.watch1 && CC1_SENSE.above_disc) || (s.watch2 && CC2_SENSE.above_disc));

    tccad_qual_timer #(
        .LIMIT(CC_QUAL_CYC)
    ) u_qual (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .cond(qual_cond),
        .done(qual_done)
    );

    always_comb begin
        next_s = s;
        // Dead battery Rd released for good once power is local
        next_s.db_released = s.db_released || VBUS_NOT_NEEDED;
        next_s.db_rd = DEAD_BATT && !next_s.db_released;
        case (s.st)
            ST_UNATT: begin
                next_s.conn = CONN_NONE;
                if (ROLE_MODE == ROLE_DRP) begin
                    if (s.drp_cnt >= DRP_PERIOD_CYC - 1) begin
                        next_s.drp_cnt = '0;
                    end else begin
                        next_s.drp_cnt = s.drp_cnt + 32'h0000_0001;
                    end
                    next_s.drp_src = next_s.drp_cnt < DRP_SRC_CYC;
                end else begin
                    next_s.drp_cnt = '0;
                    // Only a pure source keeps its pullup while idle
                    next_s.drp_src = ROLE_MODE == ROLE_SRC;
                end
                if (!src_phase) begin
                    if (VBUS_PRESENT) begin
                        next_s.st = ST_ATT;
                        next_s.conn = CONN_AS_SINK;
                        next_s.drp_cnt = '0;
                    end
                end else if (cur != CONN_NONE) begin
                    next_s.st = ST_ATT;
                    next_s.conn = cur;
                    next_s.drp_cnt = '0;
                end
            end
            ST_ATT: begin
                if (s.conn == CONN_AS_SINK) begin
                    if (!VBUS_PRESENT) begin
                        next_s.st = ST_UNATT;
                    end
                end else if (qual_done) begin
                    next_s.st = ST_UNATT;
                    next_s.conn = CONN_NONE;
                end else if (cable_only(s.conn) && (cur == CONN_VC_CC1 || cur == CONN_VC_CC2)) begin
                    // Sink arrived behind an already seen cable
                    next_s.conn = cur;
                end
            end
            ST_ERR: begin
                next_s.conn = CONN_NONE;
                if (!OT_LATCH) begin
                    next_s.st = ST_UNATT;
                end
            end
            default: begin
                next_s.st = ST_UNATT;
            end
        endcase
        if (OT_LATCH) begin
            next_s.st = ST_ERR;
            next_s.conn = CONN_NONE;
        end
        if (next_s.st == ST_UNATT) begin
            next_s.conn = CONN_NONE;
        end

        // Outputs follow the next connection so they move with it
        next_s.attached = next_s.st == ST_ATT && !cable_only(next_s.conn);
        next_s.err = next_s.st == ST_ERR;
        next_s.vbus_en = next_s.conn inside {CONN_SINK_CC1, CONN_SINK_CC2, CONN_VC_CC1,
            CONN_VC_CC2, CONN_DEBUG};
        next_s.vconn1 = next_s.conn == CONN_VC_CC1 && !fault;
        next_s.vconn2 = next_s.conn == CONN_VC_CC2 && !fault;
        next_s.pd_tx_en = next_s.st == ST_ATT && !fault;
        {next_s.watch2, next_s.watch1} = (next_s.st == ST_UNATT) ? 2'h3
            : (next_s.st == ST_ATT) ? watch_of(next_s.conn) : 2'h0;
        if (next_s.conn == CONN_AS_SINK) begin
            next_s.pull_up = 1'b0;
            next_s.orient = CC2_SENSE.adv != 2'h0;
            next_s.sink_cur = next_s.orient ? CC2_SENSE.adv : CC1_SENSE.adv;
        end else begin
            next_s.pull_up = next_s.st == ST_ATT || next_s.drp_src;
            next_s.orient = next_s.conn == CONN_SINK_CC2 || next_s.conn == CONN_VC_CC1;
            next_s.sink_cur = 2'h0;
        end
        if (next_s.st == ST_ERR) begin
            next_s.pull_up = 1'b0;
        end
        // Firmware level only after the source switch is closed
        next_s.rp_level = next_s.vbus_en ? RP_LEVEL_REQ : `TCCAD_RP_DEF;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign CC_PULLUP = s.pull_up;
    assign RP_LEVEL = s.rp_level;
    assign VBUS_EN = s.vbus_en;
    assign VCONN_CC1 = s.vconn1;
    assign VCONN_CC2 = s.vconn2;
    assign PD_TX_EN = s.pd_tx_en;
    assign WATCH_CC1 = s.watch1;
    assign WATCH_CC2 = s.watch2;
    assign ATTACHED = s.attached;
    assign ORIENT = s.orient;
    assign CONN_STATE = s.conn;
    assign SINK_CURRENT = s.sink_cur;
    assign DB_RD_EN = s.db_rd;
    assign ERR_RECOVERY = s.err;

    logic unatt_src;
    assign unatt_src = s.st == ST_UNATT && src_phase && !OT_LATCH;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // Source side pin cases: one cycle from the pins to the outputs; then general rules
    open_no_power_a: assert property (
        unatt_src && cur == CONN_NONE |=> !VBUS_EN && !ATTACHED && WATCH_CC1 && WATCH_CC2)
        else $error("power or attach with both pins open");
    sink_cc1_a: assert property (
        unatt_src && CC1_SENSE.rd && !CC2_SENSE.rd && !CC2_SENSE.ra
        |=> VBUS_EN && !VCONN_CC2 && WATCH_CC1 && !WATCH_CC2 && !ORIENT)
        else $error("sink on CC1 not handled");
    vconn_cc1_a: assert property (
        unatt_src && CC1_SENSE.ra && CC2_SENSE.rd && !fault
        |=> VBUS_EN && VCONN_CC1 && !WATCH_CC1 && WATCH_CC2)
        else $error("cable plus sink on CC2 not handled");
    cable_only_a: assert property (
        unatt_src && CC1_SENSE.ra && !CC2_SENSE.ra && !CC2_SENSE.rd
        |=> !VBUS_EN && !VCONN_CC1 && !VCONN_CC2 && !ATTACHED && WATCH_CC1)
        else $error("cable only powered something");
    debug_acc_a: assert property (
        unatt_src && CC1_SENSE.rd && CC2_SENSE.rd
        |=> CONN_STATE == CONN_DEBUG && WATCH_CC1 && WATCH_CC2)
        else $error("debug accessory not declared");
    default_rp_a: assert property (
        !VBUS_EN |-> RP_LEVEL == `TCCAD_RP_DEF)
        else $error("raised pullup before VBUS switch");
    no_early_detach_a: assert property (
        s.st == ST_ATT && s.conn != CONN_AS_SINK && !qual_cond && !$past(qual_cond) && !OT_LATCH
        |=> s.st == ST_ATT)
        else $error("detach without qualification");
    sink_detach_a: assert property (
        s.st == ST_ATT && s.conn == CONN_AS_SINK && !VBUS_PRESENT && !OT_LATCH
        |=> !ATTACHED && s.st == ST_UNATT)
        else $error("sink stayed attached without VBUS");
    protect_a: assert property (
        fault |=> !VCONN_CC1 && !VCONN_CC2 && !PD_TX_EN)
        else $error("VCONN or transmitter on during fault");
    err_recov_a: assert property (
        OT_LATCH |=> ERR_RECOVERY && !VBUS_EN && !ATTACHED)
        else $error("no error recovery on overtemperature");
    db_release_a: assert property (
        VBUS_NOT_NEEDED |=> !DB_RD_EN [*2])
        else $error("dead battery Rd kept");
    drp_stop_a: assert property (
        ATTACHED && ROLE_MODE == ROLE_DRP && !OT_LATCH && $stable(ATTACHED) |-> s.drp_cnt == '0)
        else $error("alternation ran while attached");

    // Mirror cases and the audio case of the source pin table
    sink_cc2_a: assert property (
        unatt_src && CC2_SENSE.rd && !CC1_SENSE.rd && !CC1_SENSE.ra
        |=> VBUS_EN && !VCONN_CC1 && !WATCH_CC1 && WATCH_CC2 && ORIENT)
        else $error("sink on CC2 not handled");
    cable_cc2_a: assert property (
        unatt_src && CC2_SENSE.ra && !CC2_SENSE.rd && !CC1_SENSE.ra && !CC1_SENSE.rd
        |=> !VBUS_EN && !VCONN_CC1 && !VCONN_CC2 && !ATTACHED && WATCH_CC2 && !WATCH_CC1)
        else $error("cable only on CC2 powered something");
    vconn_cc2_a: assert property (
        unatt_src && CC1_SENSE.rd && !CC1_SENSE.ra && CC2_SENSE.ra && !CC2_SENSE.rd && !fault
        |=> VBUS_EN && VCONN_CC2 && !VCONN_CC1 && WATCH_CC1 && !WATCH_CC2)
        else $error("cable plus sink on CC1 not handled");
    audio_acc_a: assert property (
        unatt_src && CC1_SENSE.ra && CC2_SENSE.ra && !CC1_SENSE.rd && !CC2_SENSE.rd
        |=> CONN_STATE == CONN_AUDIO && !VBUS_EN && WATCH_CC1 && WATCH_CC2)
        else $error("audio accessory not declared");

    // Detach and sink side
    qual_detach_a: assert property (
        s.st == ST_ATT && s.conn != CONN_AS_SINK && qual_done && !OT_LATCH
        |=> !ATTACHED && !VBUS_EN && WATCH_CC1 && WATCH_CC2)
        else $error("qualified detach not taken");
    sink_pulldown_a: assert property (
        ROLE_MODE == ROLE_SNK && s.st == ST_UNATT && !OT_LATCH |=> !CC_PULLUP)
        else $error("sink drove pullup current");
    sink_orient_a: assert property (
        s.st == ST_ATT && s.conn == CONN_AS_SINK && VBUS_PRESENT && !OT_LATCH
        && CC2_SENSE.adv == `TCCAD_RP_3A0
        |=> ORIENT && SINK_CURRENT == `TCCAD_RP_3A0)
        else $error("sink orientation or current wrong");

    // Alternation slots; a full or empty duty has no slot edge
    drp_to_snk_a: assert property (
        ROLE_MODE == ROLE_DRP && s.st == ST_UNATT && s.drp_cnt == DRP_SRC_CYC - 1
        && DRP_SRC_CYC < DRP_PERIOD_CYC && cur == CONN_NONE && !OT_LATCH
        |=> !CC_PULLUP)
        else $error("source slot overran");
    drp_to_src_a: assert property (
        ROLE_MODE == ROLE_DRP && s.st == ST_UNATT && s.drp_cnt == DRP_PERIOD_CYC - 1
        && DRP_SRC_CYC > 0 && !VBUS_PRESENT && !OT_LATCH
        |=> CC_PULLUP)
        else $error("source slot missed at period end");
    drp_bound_a: assert property (
        s.drp_cnt < DRP_PERIOD_CYC)
        else $error("alternation count out of range");

    // Main scenarios
    sink_attach_c: cover property (unatt_src && cur == CONN_SINK_CC2 ##1 ATTACHED);
    detach_c: cover property (qual_done ##1 !ATTACHED);
    audio_c: cover property (unatt_src && cur == CONN_AUDIO ##1 ATTACHED && !VBUS_EN);
    drp_sink_c: cover property (ROLE_MODE == ROLE_DRP && !s.drp_src && VBUS_PRESENT ##1 ATTACHED);
    upgrade_c: cover property (CONN_STATE == CONN_CABLE_CC1 ##1 CONN_STATE == CONN_VC_CC1);

endmodule

// ---- rtl/tccad_map.svh ----
// Purpose: Constants for the CC attach and detach block
// Assumes: 200 MHz system clock
// Notes: Counts derive from times in their own units
`ifndef TCCAD_MAP_SVH
`define TCCAD_MAP_SVH

`define TCCAD_CLK_PERIOD_NS 5
// Disconnect qualification time on a watched CC pin
`define TCCAD_CC_QUAL_TIME_NS 10000
`define TCCAD_CC_QUAL_CYC ((`TCCAD_CC_QUAL_TIME_NS + `TCCAD_CLK_PERIOD_NS - 1) / `TCCAD_CLK_PERIOD_NS)
// Dual-role alternation period and source share
`define TCCAD_DRP_PERIOD_NS 50000000
`define TCCAD_DRP_PERIOD_CYC (`TCCAD_DRP_PERIOD_NS / `TCCAD_CLK_PERIOD_NS)
`define TCCAD_DRP_DUTY_PCT 50
// Pullup advertisement codes
`define TCCAD_RP_DEF 2'h0
`define TCCAD_RP_1A5 2'h1
`define TCCAD_RP_3A0 2'h2

`endif

// ---- rtl/tccad_pkg.sv ----
// Purpose: Types for the CC attach and detach block
// Assumes: Analog CC sensing arrives as comparator bits
// Notes: Constants live in tccad_map.svh
package tccad_pkg;

    typedef enum logic [1:0] {
        ROLE_SRC = 2'h0,
        ROLE_SNK = 2'h1,
        ROLE_DRP = 2'h2
    } tccad_role_type;

    // Gray codes along unattached, attached, error
    typedef enum logic [1:0] {
        ST_UNATT = 2'h0,
        ST_ATT = 2'h1,
        ST_ERR = 2'h3
    } tccad_state_type;

    typedef enum logic [3:0] {
        CONN_NONE = 4'h0,
        CONN_SINK_CC1 = 4'h1,
        CONN_SINK_CC2 = 4'h2,
        CONN_CABLE_CC1 = 4'h3,
        CONN_CABLE_CC2 = 4'h4,
        CONN_VC_CC1 = 4'h5,
        CONN_VC_CC2 = 4'h6,
        CONN_DEBUG = 4'h7,
        CONN_AUDIO = 4'h8,
        CONN_AS_SINK = 4'h9
    } tccad_conn_type;

    // Per-pin comparator results
    typedef struct packed {
        logic ra;
        logic rd;
        logic above_disc;
        logic ovp;
        logic [1:0] adv;
    } tccad_cc_type;

    typedef struct packed {
        logic [31:0] cnt;
        logic done;
    } tccad_tmr_type;

    typedef struct packed {
        tccad_state_type st;
        tccad_conn_type conn;
        logic drp_src;
        logic [31:0] drp_cnt;
        logic vbus_en;
        logic vconn1;
        logic vconn2;
        logic pd_tx_en;
        logic orient;
        logic watch1;
        logic watch2;
        logic [1:0] rp_level;
        logic [1:0] sink_cur;
        logic pull_up;
        logic db_rd;
        logic db_released;
        logic err;
        logic attached;
    } tccad_ctl_type;

endpackage

// ---- rtl/tccad_qual_timer.sv ----
// Purpose: Counts how long a condition has held without a break
// Assumes: Condition is synchronous to clk
// Notes: Done stays high while the condition keeps holding
`timescale 1ns/1ps
module tccad_qual_timer #(
    parameter int unsigned LIMIT = 2000
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, low
    input wire logic cond, // Condition to qualify
    output logic done // Held for LIMIT cycles
);
    import tccad_pkg::*;

    tccad_tmr_type s;
    tccad_tmr_type next_s;

    always_comb begin
        next_s = s;
        if (!cond) begin
            next_s.cnt = '0;
            next_s.done = 1'b0;
        end else if (s.cnt < LIMIT - 1) begin
            next_s.cnt = s.cnt + 32'h0000_0001;
            next_s.done = 1'b0;
        end else begin
            next_s.done = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;

endmodule

// ---- testbench/tccad_far_model.sv ----
// Purpose: Far end of the CC pins: open, Ra, Rd or a source pullup
// Assumes: Comparator view is ideal, no analog settling
// Notes: Ra and Rd only show while the port drives pullup current
`timescale 1ns/1ps
module tccad_far_model (
    input wire logic cc_pullup, // Port drives pullup current
    input wire logic [1:0] kind1, // CC1 far end: 0 open, 1 Ra, 2 Rd, 3 source
    input wire logic [1:0] kind2, // CC2 far end, same coding
    input wire logic [1:0] adv, // Level a far source advertises
    input wire logic [1:0] ovp, // Overvoltage on CC2, CC1
    output tccad_pkg::tccad_cc_type cc1, // CC1 comparators
    output tccad_pkg::tccad_cc_type cc2, // CC2 comparators
    output logic vbus // Far source powers VBUS
);
    import tccad_pkg::*;

    // An open pin under pullup rises above the disconnect level
    function automatic tccad_cc_type pin(input logic [1:0] k, input logic pu, input logic [1:0] a,
                                         input logic ov);
        return {k == 2'h1 && pu, k == 2'h2 && pu, k == 2'h0 && pu, ov, (k == 2'h3 && !pu) ? a : 2'h0};
    endfunction

    assign cc1 = pin(kind1, cc_pullup, adv, ovp[0]);
    assign cc2 = pin(kind2, cc_pullup, adv, ovp[1]);
    assign vbus = (kind1 == 2'h3) || (kind2 == 2'h3);
endmodule

// ---- testbench/tccad_attach_detect_tb.sv ----
// Purpose: Self-checking bench for the CC attach and detach block
// Assumes: Short qualification and alternation counts
// Notes: Detach timing follows the hand-over latency exactly
`timescale 1ns/1ps
`include "tccad_map.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tccad_attach_detect_tb;
    import tccad_pkg::*;
    localparam int unsigned QUAL = 4;
    localparam int unsigned DRP_P = 20;
    // {cc1 kind, cc2 kind, conn, vbus, vconn1, vconn2, watch1, watch2, attached}
    localparam logic [13:0] TBL [8] = '{
        {2'h2, 2'h0, 4'h1, 6'b100101}, {2'h0, 2'h2, 4'h2, 6'b100011},
        {2'h1, 2'h0, 4'h3, 6'b000100}, {2'h0, 2'h1, 4'h4, 6'b000010},
        {2'h1, 2'h2, 4'h5, 6'b110011}, {2'h2, 2'h1, 4'h6, 6'b101101},
        {2'h2, 2'h2, 4'h7, 6'b100111}, {2'h1, 2'h1, 4'h8, 6'b000111}};
    logic sys_clk, rst_n, vbus_present, rev_current, ot_latch, dead_batt, vbus_not_needed;
    logic [1:0] rp_level_req, kind1, kind2, adv, ovp;
    tccad_role_type role;
    tccad_cc_type cc1_sense, cc2_sense;
    logic cc_pullup, vbus_en, vconn_cc1, vconn_cc2, pd_tx_en, watch_cc1, watch_cc2;
    logic attached, orient, db_rd_en, err_recovery;
    logic [1:0] rp_level, sink_current;
    tccad_conn_type conn_state;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    tccad_attach_detect #(.CC_QUAL_CYC(QUAL), .DRP_PERIOD_CYC(DRP_P), .DRP_DUTY_PCT(50)) dut_u (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .ROLE_MODE(role), .CC1_SENSE(cc1_sense), .CC2_SENSE(cc2_sense),
        .VBUS_PRESENT(vbus_present), .REV_CURRENT(rev_current), .OT_LATCH(ot_latch),
        .DEAD_BATT(dead_batt), .VBUS_NOT_NEEDED(vbus_not_needed), .RP_LEVEL_REQ(rp_level_req),
        .CC_PULLUP(cc_pullup), .RP_LEVEL(rp_level), .VBUS_EN(vbus_en), .VCONN_CC1(vconn_cc1),
        .VCONN_CC2(vconn_cc2), .PD_TX_EN(pd_tx_en), .WATCH_CC1(watch_cc1), .WATCH_CC2(watch_cc2),
        .ATTACHED(attached), .ORIENT(orient), .CONN_STATE(conn_state), .SINK_CURRENT(sink_current),
        .DB_RD_EN(db_rd_en), .ERR_RECOVERY(err_recovery));

    tccad_far_model far_u (.cc_pullup(cc_pullup), .kind1(kind1), .kind2(kind2), .adv(adv), .ovp(ovp),
        .cc1(cc1_sense), .cc2(cc2_sense), .vbus(vbus_present));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Sample just after the edge so that edge's updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_open();
        tick(2);
        `CHK("idle", 6'b000110, {vbus_en, vconn_cc1, vconn_cc2, watch_cc1, watch_cc2, attached})
        `CHK("pullup", 1'b1, cc_pullup)
        `CHK("rp default", `TCCAD_RP_DEF, rp_level)
    endtask

    task automatic t_table();
        logic [13:0] e;
        for (int i = 0; i < 8; i++) begin
            e = TBL[i];
            @(posedge sys_clk);
            kind1 <= e[13:12];
            kind2 <= e[11:10];
            tick(3);
            `CHK("conn", tccad_conn_type'(e[9:6]), conn_state)
            `CHK("power", e[5:0], {vbus_en, vconn_cc1, vconn_cc2, watch_cc1, watch_cc2, attached})
            if (i < 2) `CHK("orient", 1'(i), orient)
            if (e[5]) `CHK("rp level", `TCCAD_RP_3A0, rp_level)
            if (i == 0) begin
                // A bounce shorter than the qualification must not detach
                @(posedge sys_clk);
                kind1 <= 2'h0;
                repeat (QUAL - 1) @(posedge sys_clk);
                kind1 <= 2'h2;
                tick(3);
                `CHK("bounce", 1'b1, attached)
            end
            if (i == 4) begin
                @(posedge sys_clk);
                kind1 <= 2'h0;
                tick(QUAL + 4);
                `CHK("ignored pin", 1'b1, attached)
            end
            @(posedge sys_clk);
            kind2 <= 2'h0;
            if (i < 6) kind1 <= 2'h0;
            tick(QUAL);
            if (e[0]) `CHK("held", 1'b1, attached)
            tick(1);
            `CHK("dropped", 1'b0, attached)
            @(posedge sys_clk);
            kind1 <= 2'h0;
            tick(QUAL + 4);
            `CHK("detached", CONN_NONE, conn_state)
        end
    endtask

    task automatic t_fault();
        @(posedge sys_clk);
        kind1 <= 2'h1;
        kind2 <= 2'h2;
        tick(3);
        `CHK("vconn on", 1'b1, vconn_cc1)
        @(posedge sys_clk);
        ovp <= 2'b10;
        tick(2);
        `CHK("ovp", 3'b000, {vconn_cc1, vconn_cc2, pd_tx_en})
        @(posedge sys_clk);
        ovp <= 2'b00;
        rev_current <= 1'b1;
        tick(2);
        `CHK("reverse", 3'b000, {vconn_cc1, vconn_cc2, pd_tx_en})
        @(posedge sys_clk);
        rev_current <= 1'b0;
        tick(2);
        `CHK("vconn back", 1'b1, vconn_cc1)
        @(posedge sys_clk);
        ot_latch <= 1'b1;
        tick(2);
        `CHK("err", 2'b10, {err_recovery, vconn_cc1})
        @(posedge sys_clk);
        ot_latch <= 1'b0;
        kind1 <= 2'h0;
        kind2 <= 2'h0;
        tick(QUAL + 6);
        `CHK("err off", 1'b0, err_recovery)
    endtask

    task automatic t_sink();
        @(posedge sys_clk);
        role <= ROLE_SNK;
        kind2 <= 2'h3;
        adv <= `TCCAD_RP_3A0;
        tick(3);
        `CHK("pulldown", 1'b0, cc_pullup)
        `CHK("sink", CONN_AS_SINK, conn_state)
        `CHK("current", `TCCAD_RP_3A0, sink_current)
        @(posedge sys_clk);
        kind2 <= 2'h0;
        tick(2);
        `CHK("sink gone", 1'b0, attached)
    endtask

    task automatic t_drp();
        int hi;
        int w;
        @(posedge sys_clk);
        role <= ROLE_DRP;
        tick(2);
        hi = 0;
        for (int k = 0; k < 2 * DRP_P; k++) begin
            tick(1);
            hi += int'(cc_pullup === 1'b1);
        end
        `CHK("drp duty", DRP_P, hi)
        @(posedge sys_clk);
        kind1 <= 2'h2;
        w = 0;
        while (attached !== 1'b1 && w < 3 * DRP_P) begin
            tick(1);
            w++;
        end
        `CHK("drp attach", 1'b1, attached)
        hi = 0;
        for (int k = 0; k < 2 * DRP_P; k++) begin
            tick(1);
            hi += int'(cc_pullup === 1'b1);
        end
        `CHK("drp stopped", 2 * DRP_P, hi)
        @(posedge sys_clk);
        kind1 <= 2'h0;
        tick(QUAL + 6);
    endtask

    task automatic t_dead();
        @(posedge sys_clk);
        role <= ROLE_SNK;
        dead_batt <= 1'b1;
        tick(2);
        `CHK("dead rd", 1'b1, db_rd_en)
        `CHK("sink idle", 1'b0, cc_pullup)
        @(posedge sys_clk);
        vbus_not_needed <= 1'b1;
        @(posedge sys_clk);
        vbus_not_needed <= 1'b0;
        tick(2);
        `CHK("rd released", 1'b0, db_rd_en)
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Whole run is a few hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        role = ROLE_SRC;
        kind1 = 2'h0;
        kind2 = 2'h0;
        adv = 2'h0;
        ovp = 2'b00;
        rev_current = 1'b0;
        ot_latch = 1'b0;
        dead_batt = 1'b0;
        vbus_not_needed = 1'b0;
        rp_level_req = `TCCAD_RP_3A0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_open();
        t_table();
        t_fault();
        t_sink();
        t_drp();
        t_dead();
        stop_test();
    end
endmodule
